//--- shared/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define OFF_ENABLE      12'h000
`define OFF_RAW_IRQ     12'h004
`define OFF_IRQ_GATE    12'h008
`define OFF_MASKED_IRQ  12'h00C
`define OFF_OVERFLOW    12'h010
`define OFF_TRIG_SEL    12'h014
`define OFF_UNDERFLOW   12'h018
`define OFF_PRIORITY    12'h020
`define OFF_SW_TRIG     12'h028
`define OFF_AVG_CTRL    12'h030
`define OFF_SEQ_BASE    12'h040
`define OFF_SEQ_END     12'h0C0
`define SEQ_STRIDE_LOG2 5
`define OFF_LOOPBACK    12'h100
`define PRIORITY_RESET  16'h3210
`define CTL3_RESET      4'h2
`define CTL_DIFF_BIT    0
`define CTL_END_BIT     1
`define CTL_IRQ_BIT     2
`define CTL_TEMP_BIT    3
`define TRIG_SOFTWARE   4'h0
`define TRIG_ALWAYS     4'hF
`define ADC_CLK_DIV     8'h2
`define CONV_CYCLES     8'h10
`endif

//--- shared/adc_seq_pkg.sv
package adc_seq_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic        valid;
    } axi_addr_t;
    typedef struct packed {
        logic [3:0] chan;
        logic       temp;
        logic       diff;
    } conv_sel_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONV, SEQ_PUSH} seq_state_t;
endpackage

//--- design/adc_seq_ctrl.sv
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_seq_ctrl (
    input  wire logic               aclk,           // Bus and core clock
    input  wire logic               aresetn,        // Synchronous reset, active low
    input  wire logic [11:0]        s_axi_awaddr,   // Write address
    input  wire logic               s_axi_awvalid,  // Write address valid
    output logic                    s_axi_awready,  // Write address ready
    input  wire logic [31:0]        s_axi_wdata,    // Write data
    input  wire logic [3:0]         s_axi_wstrb,    // Write strobes
    input  wire logic               s_axi_wvalid,   // Write data valid
    output logic                    s_axi_wready,   // Write data ready
    output logic [1:0]              s_axi_bresp,    // Write response
    output logic                    s_axi_bvalid,   // Write response valid
    input  wire logic               s_axi_bready,   // Write response ready
    input  wire logic [11:0]        s_axi_araddr,   // Read address
    input  wire logic               s_axi_arvalid,  // Read address valid
    output logic                    s_axi_arready,  // Read address ready
    output logic [31:0]             s_axi_rdata,    // Read data
    output logic [1:0]              s_axi_rresp,    // Read response
    output logic                    s_axi_rvalid,   // Read data valid
    input  wire logic               s_axi_rready,   // Read data ready
    input  wire logic [3:0]         periph_trig,    // Timer, comparator, PWM, GPIO triggers
    output adc_seq_pkg::conv_sel_t  conv_sel,       // Selection to analog core
    output logic                    conv_start,     // Conversion start pulse
    input  wire logic               conv_done,      // Conversion done from core
    input  wire logic [9:0]         conv_data,      // Conversion result
    output logic                    irq             // Module interrupt
);
    import adc_seq_pkg::*;

    logic [3:0]  en_r, gate_r, raw_r, ovf_r, unf_r, swt_r;
    logic [15:0] trig_sel_r;
    logic [15:0] pri_r;
    logic [2:0]  avg_r;
    logic        loop_r;
    logic [31:0] mux_r [4];
    logic [31:0] ctl_r [4];
    logic [9:0]  mem_r [4][8];
    logic [3:0]  head_r [4];
    logic [3:0]  tail_r [4];
    logic [3:0]  trig_s1_r, trig_s2_r;
    logic [3:0]  pend_r;
    logic        conv_done_s1_r, conv_done_s2_r;
    logic [9:0]  data_s1_r, data_s2_r;
    seq_state_t  state_r;
    logic [1:0]  cur_r;
    logic [2:0]  step_r;
    logic [6:0]  acc_cnt_r;
    logic [15:0] acc_r;
    logic [7:0]  div_r;
    logic [7:0]  lb_cnt_r;
    logic        waiting_r;
    logic [9:0]  lb_val_r;

    // Write channel
    logic        aw_hold_r, w_hold_r;
    logic [11:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic        wr_go, rd_go;
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r  <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
        end
    end
    assign s_axi_bresp = 2'h0;

    // Decoded write strobes
    logic       wr_seq;
    logic [1:0] wr_sn;
    logic [2:0] wr_sr;
    assign wr_seq = wr_go && aw_addr_r >= `OFF_SEQ_BASE && aw_addr_r < `OFF_SEQ_END;
    assign wr_sn  = 2'(aw_addr_r[6:5] - 2'h2);
    assign wr_sr  = aw_addr_r[4:2];

    // Read channel
    logic [11:0] ar_addr;
    logic [1:0]  rd_sn;
    logic        rd_fifo;
    logic [31:0] rd_word;
    logic [3:0]  full_v, empty_v;
    assign ar_addr = s_axi_araddr;
    assign rd_sn   = 2'(ar_addr[6:5] - 2'h2);
    assign rd_go   = s_axi_arvalid && s_axi_arready;
    assign rd_fifo = rd_go && ar_addr >= `OFF_SEQ_BASE && ar_addr < `OFF_SEQ_END
                     && ar_addr[4:2] == 3'h2;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (ar_addr)
            `OFF_ENABLE:     rd_word = {28'h0, en_r};
            `OFF_RAW_IRQ:    rd_word = {28'h0, raw_r};
            `OFF_IRQ_GATE:   rd_word = {28'h0, gate_r};
            `OFF_MASKED_IRQ: rd_word = {28'h0, raw_r & gate_r};
            `OFF_OVERFLOW:   rd_word = {28'h0, ovf_r};
            `OFF_TRIG_SEL:   rd_word = {16'h0, trig_sel_r};
            `OFF_UNDERFLOW:  rd_word = {28'h0, unf_r};
            `OFF_PRIORITY:   rd_word = {16'h0, pri_r};
            `OFF_AVG_CTRL:   rd_word = {29'h0, avg_r};
            `OFF_LOOPBACK:   rd_word = {31'h0, loop_r};
            default: begin
                if (ar_addr >= `OFF_SEQ_BASE && ar_addr < `OFF_SEQ_END && ~|ar_addr[1:0]) begin
                    unique case (ar_addr[4:2])
                        3'h0: rd_word = mux_r[rd_sn];
                        3'h1: rd_word = ctl_r[rd_sn];
                        3'h2: rd_word = {22'h0, mem_r[rd_sn][tail_r[rd_sn][2:0]]};
                        3'h3: rd_word = {19'h0, full_v[rd_sn], 3'h0, empty_v[rd_sn],
                                         head_r[rd_sn], tail_r[rd_sn]};
                        default: rd_word = 32'h0000_0000;
                    endcase
                end
            end
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_rresp = 2'h0;

    // Control registers; config stays writable while disabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_r       <= 4'h0;
            gate_r     <= 4'h0;
            trig_sel_r <= 16'h0000;
            pri_r      <= `PRIORITY_RESET;
            avg_r      <= 3'h0;
            loop_r     <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                mux_r[i] <= 32'h0000_0000;
                ctl_r[i] <= (i == 3) ? {28'h0, `CTL3_RESET} : 32'h0000_0000;
            end
        end else if (wr_go) begin
            unique case (aw_addr_r)
                `OFF_ENABLE:   en_r       <= w_data_r[3:0];
                `OFF_IRQ_GATE: gate_r     <= w_data_r[3:0];
                `OFF_TRIG_SEL: trig_sel_r <= w_data_r[15:0];
                `OFF_PRIORITY: pri_r      <= w_data_r[15:0] & 16'h3333;
                `OFF_AVG_CTRL: avg_r      <= (w_data_r[2:0] > 3'h6) ? 3'h6 : w_data_r[2:0];
                `OFF_LOOPBACK: loop_r     <= w_data_r[0];
                default: begin
                    if (wr_seq && wr_sr == 3'h0)
                        mux_r[wr_sn] <= w_data_r;
                    if (wr_seq && wr_sr == 3'h1)
                        ctl_r[wr_sn] <= w_data_r;
                end
            endcase
        end
    end

    // Trigger synchronisers, trigger select decode and software trigger pulse
    logic [3:0] trig_hit;
    logic       step_irq, step_end, push_now;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_s1_r <= 4'h0;
            trig_s2_r <= 4'h0;
        end else begin
            trig_s1_r <= periph_trig;
            trig_s2_r <= trig_s1_r;
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            trig_hit[i] = 1'b0;
            unique case (trig_sel_r[4*i +: 4])
                `TRIG_SOFTWARE: trig_hit[i] = swt_r[i];
                `TRIG_ALWAYS:   trig_hit[i] = 1'b1;
                4'h1, 4'h2, 4'h3, 4'h4: trig_hit[i] = trig_s2_r[trig_sel_r[4*i +: 2] - 2'h1];
                default:        trig_hit[i] = 1'b0;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swt_r <= 4'h0;
        end else begin
            swt_r <= (wr_go && aw_addr_r == `OFF_SW_TRIG) ? w_data_r[3:0] : 4'h0;
        end
    end

    // Priority arbiter
    logic [1:0] win;
    logic       win_ok;
    always_comb begin
        win    = 2'h0;
        win_ok = 1'b0;
        for (int p = 3; p >= 0; p--) begin
            for (int i = 3; i >= 0; i--) begin
                if ((pend_r[i] || trig_hit[i]) && en_r[i]
                    && pri_r[4*i +: 2] == 2'(p)) begin
                    win    = 2'(i);
                    win_ok = 1'b1;
                end
            end
        end
    end

    // Converter pacing, loopback and input capture
    logic        got;
    logic [9:0]  got_val;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= 8'h0;
            conv_done_s1_r <= 1'b0;
            conv_done_s2_r <= 1'b0;
            data_s1_r <= 10'h000;
            data_s2_r <= 10'h000;
        end else begin
            div_r <= (div_r == `ADC_CLK_DIV - 8'h1) ? 8'h0 : 8'(div_r + 8'h1);
            conv_done_s1_r <= conv_done;
            conv_done_s2_r <= conv_done_s1_r;
            data_s1_r <= conv_data;
            data_s2_r <= data_s1_r;
        end
    end
    assign got     = waiting_r && (loop_r ? lb_cnt_r == `CONV_CYCLES : conv_done_s2_r);
    assign got_val = loop_r ? lb_val_r : data_s2_r;

    logic [3:0] cnib, mnib;
    logic [6:0] avg_n;
    assign cnib     = ctl_r[cur_r][4*step_r +: 4];
    assign mnib     = mux_r[cur_r][4*step_r +: 4];
    assign avg_n    = 7'(1 << avg_r);
    assign step_irq = cnib[`CTL_IRQ_BIT];
    assign step_end = cnib[`CTL_END_BIT] || step_r == 3'(depth(cur_r) - 1);

    function automatic logic [3:0] depth(input logic [1:0] s);
        unique case (s)
            2'h0:       depth = 4'h8;
            2'h1, 2'h2: depth = 4'h4;
            default:    depth = 4'h1;
        endcase
    endfunction

    // Sequencer engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r   <= SEQ_IDLE;
            cur_r     <= 2'h0;
            step_r    <= 3'h0;
            acc_cnt_r <= 7'h0;
            acc_r     <= 16'h0;
            pend_r    <= 4'h0;
            waiting_r <= 1'b0;
            lb_cnt_r  <= 8'h0;
            lb_val_r  <= 10'h000;
            conv_start <= 1'b0;
            conv_sel  <= '0;
        end else begin
            conv_start <= 1'b0;
            pend_r <= (pend_r | trig_hit) & en_r;
            if (waiting_r && loop_r)
                lb_cnt_r <= 8'(lb_cnt_r + 8'h1);
            unique case (state_r)
                SEQ_IDLE: begin
                    if (win_ok && div_r == 8'h0) begin
                        cur_r  <= win;
                        step_r <= 3'h0;
                        pend_r[win] <= 1'b0;
                        state_r <= SEQ_CONV;
                    end
                end
                SEQ_CONV: begin
                    if (!waiting_r && div_r == 8'h0) begin
                        conv_sel <= '{chan: mnib, temp: cnib[`CTL_TEMP_BIT],
                                      diff: cnib[`CTL_DIFF_BIT]};
                        conv_start <= 1'b1;
                        waiting_r  <= 1'b1;
                        lb_cnt_r   <= 8'h0;
                    end else if (got) begin
                        waiting_r <= 1'b0;
                        lb_val_r  <= 10'(lb_val_r + 10'h1);
                        acc_r     <= 16'(acc_r + {6'h0, got_val});
                        if (acc_cnt_r == 7'(avg_n - 7'h1)) begin
                            acc_cnt_r <= 7'h0;
                            state_r   <= SEQ_PUSH;
                        end else begin
                            acc_cnt_r <= 7'(acc_cnt_r + 7'h1);
                        end
                    end
                end
                SEQ_PUSH: begin
                    acc_r <= 16'h0;
                    if (step_end) begin
                        state_r <= SEQ_IDLE;
                    end else begin
                        step_r  <= 3'(step_r + 3'h1);
                        state_r <= SEQ_CONV;
                    end
                end
            endcase
        end
    end
    assign push_now = state_r == SEQ_PUSH;

    // Result FIFOs and flags
    logic [9:0] avg_val;
    assign avg_val = 10'(acc_r >> avg_r);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            empty_v[i] = head_r[i] == tail_r[i];
            full_v[i]  = head_r[i][3] != tail_r[i][3]
                         && (head_r[i][2:0] & 3'(depth(2'(i)) - 1))
                            == (tail_r[i][2:0] & 3'(depth(2'(i)) - 1));
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                head_r[i] <= 4'h0;
                tail_r[i] <= 4'h0;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (push_now && cur_r == 2'(i) && !full_v[i]) begin
                    mem_r[i][head_r[i][2:0]] <= avg_val;
                    head_r[i] <= wrap(head_r[i], 2'(i));
                end
                if (rd_fifo && rd_sn == 2'(i) && !empty_v[i])
                    tail_r[i] <= wrap(tail_r[i], 2'(i));
            end
        end
    end
    function automatic logic [3:0] wrap(input logic [3:0] p, input logic [1:0] s);
        if (p[2:0] == 3'(depth(s) - 1))
            wrap = {~p[3], 3'h0};
        else
            wrap = 4'(p + 4'h1);
    endfunction

    // Status flags: set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_r <= 4'h0;
            unf_r <= 4'h0;
            raw_r <= 4'h0;
            irq   <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (push_now && cur_r == 2'(i) && full_v[i])
                    ovf_r[i] <= 1'b1;
                else if (wr_go && aw_addr_r == `OFF_OVERFLOW && w_data_r[i])
                    ovf_r[i] <= 1'b0;
                if (rd_fifo && rd_sn == 2'(i) && empty_v[i])
                    unf_r[i] <= 1'b1;
                else if (wr_go && aw_addr_r == `OFF_UNDERFLOW && w_data_r[i])
                    unf_r[i] <= 1'b0;
                if (push_now && cur_r == 2'(i) && step_irq)
                    raw_r[i] <= 1'b1;
                else if (wr_go && aw_addr_r == `OFF_MASKED_IRQ && w_data_r[i])
                    raw_r[i] <= 1'b0;
            end
            irq <= |(raw_r & gate_r);
        end
    end
endmodule

//--- dv/adc_seq_ctrl_chk.sv
`timescale 1ns/1ps
module adc_seq_ctrl_chk (
    input wire logic        aclk,          // Clock
    input wire logic        aresetn,       // Reset, active low
    input wire logic        s_axi_awvalid, // Write address valid
    input wire logic        s_axi_awready, // Write address ready
    input wire logic [1:0]  s_axi_bresp,   // Write response
    input wire logic        s_axi_bvalid,  // Write response valid
    input wire logic        s_axi_bready,  // Write response ready
    input wire logic        s_axi_arvalid, // Read address valid
    input wire logic        s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata,   // Read data
    input wire logic [1:0]  s_axi_rresp,   // Read response
    input wire logic        s_axi_rvalid,  // Read data valid
    input wire logic        s_axi_rready,  // Read data ready
    input wire logic        conv_start,    // Conversion start
    input wire logic        irq            // Module interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
        else $error("write answer missing");
    rresp_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    start_pulse_a: assert property (conv_start |=> !conv_start [*3])
        else $error("conversion start not a single pulse");
    reset_quiet_a: assert property ($rose(aresetn) |-> !irq && !conv_start && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule
bind adc_seq_ctrl adc_seq_ctrl_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .irq);

//--- dv/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
    input wire logic               aclk,      // Clock
    input wire logic               aresetn,   // Reset, active low
    input wire logic               slow,      // Long conversion time
    input adc_seq_pkg::conv_sel_t  conv_sel,  // Selection from sequencer
    input wire logic               conv_start, // Start pulse
    output logic                   conv_done, // Done, two cycles
    output logic [9:0]             conv_data  // Result
);
    import adc_seq_pkg::*;
    int         cnt;
    logic [9:0] res_r;
    // Result encodes the selection so the bench can tell steps apart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt       <= 0;
            conv_done <= 1'b0;
            conv_data <= 10'h2AA;
        end else begin
            if (conv_start) begin
                cnt   <= slow ? 60 : 8;
                res_r <= {conv_sel.temp, conv_sel.diff, 4'h0, conv_sel.chan};
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            conv_done <= (cnt == 6 || cnt == 5);
            // Outside the hold window the data toggles every cycle
            conv_data <= (cnt <= 7 && cnt >= 2) ? res_r : ~conv_data;
        end
    end
endmodule

//--- dv/adc_seq_ctrl_bench.sv
`timescale 1ns/1ps
module adc_seq_ctrl_bench;
    import adc_seq_pkg::*;
    logic        aclk, aresetn, slow, conv_start, conv_done, irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, periph_trig;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [9:0]  conv_data;
    conv_sel_t   conv_sel;
    int          n_mismatch, n_checks;
    adc_seq_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_trig, .conv_sel, .conv_start,
        .conv_done, .conv_data, .irq);
    adc_core_model core_u (.aclk, .aresetn, .slow, .conv_sel, .conv_start, .conv_done,
        .conv_data);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic tmo;
        n_mismatch++;
        $display("[FAIL] %0t wait ran out", $time);
        results();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        if (n >= 100) tmo();
    endtask
    task automatic rdw(input logic [11:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 100);
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (n >= 100) tmo();
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rdw(a);
        chk(rd, e);
    endtask
    task automatic wpoll(input logic [11:0] a, input logic [31:0] m);
        int n;
        n = 0;
        do begin
            rdw(a);
            n++;
        end while ((rd & m) !== m && n < 100);
        if (n >= 100) tmo();
    endtask
    task automatic wirq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 400) tmo();
    endtask
    task automatic t_reset;
        rchk(12'h020, 32'h0000_3210);
        rchk(12'h0A4, 32'h0000_0002);
        rchk(12'h04C, 32'h0000_0100);
        rchk(12'h030, 32'h0000_0000);
        rchk(12'h0C8, 32'h0000_0000);
    endtask
    // Three steps, irq on steps 1 and 2, end on step 2
    task automatic t_seq0;
        slow <= 1'b1;
        wr(12'h040, 32'h0000_0531);
        wr(12'h044, 32'h0000_0E50);
        rchk(12'h044, 32'h0000_0E50);
        wr(12'h014, 32'h0000_0000);
        wr(12'h008, 32'h0000_0001);
        wr(12'h000, 32'h0000_0001);
        wr(12'h028, 32'h0000_0001);
        wirq();
        rchk(12'h004, 32'h0000_0001);
        rchk(12'h00C, 32'h0000_0001);
        wr(12'h00C, 32'h0000_0001);
        rchk(12'h004, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0);
        wirq();
        rchk(12'h048, 32'h0000_0001);
        rchk(12'h048, 32'h0000_0103);
        rchk(12'h048, 32'h0000_0205);
        rchk(12'h04C, 32'h0000_0133);
        rdw(12'h048);
        rchk(12'h018, 32'h0000_0001);
        wr(12'h018, 32'h0000_0001);
        rchk(12'h018, 32'h0000_0000);
        wr(12'h00C, 32'h0000_0001);
    endtask
    // Masked-off sequencer 3 overruns its one-deep buffer
    task automatic t_seq3;
        slow <= 1'b0;
        wr(12'h000, 32'h0000_0000);
        wr(12'h008, 32'h0000_0000);
        wr(12'h0A0, 32'h0000_0007);
        wr(12'h0A4, 32'h0000_0006);
        wr(12'h000, 32'h0000_0008);
        wr(12'h028, 32'h0000_0009);
        wpoll(12'h004, 32'h0000_0008);
        chk({31'h0, irq}, 32'h0);
        rchk(12'h00C, 32'h0000_0000);
        rchk(12'h04C, 32'h0000_0133);
        wr(12'h028, 32'h0000_0008);
        wpoll(12'h010, 32'h0000_0008);
        rchk(12'h0A8, 32'h0000_0007);
        wr(12'h010, 32'h0000_0008);
        rchk(12'h010, 32'h0000_0000);
    endtask
    // One-cycle pulse on trigger pin 0
    task automatic pulse;
        @(posedge aclk);
        periph_trig <= 4'h1;
        @(posedge aclk);
        periph_trig <= 4'h0;
    endtask
    // Seq3 outranks seq0; pin trigger; loopback averaging; always trigger
    task automatic t_mix;
        int n;
        wr(12'h000, 32'h0000_0000);
        wr(12'h00C, 32'h0000_000F);
        wr(12'h044, 32'h0000_0006);
        wr(12'h020, 32'h0000_0213);
        wr(12'h000, 32'h0000_0009);
        wr(12'h028, 32'h0000_0009);
        n = 0;
        do begin
            rdw(12'h004);
            n++;
        end while (rd == 32'h0 && n < 100);
        chk(rd, 32'h0000_0008);
        wpoll(12'h004, 32'h0000_0009);
        rchk(12'h048, 32'h0000_0001);
        rchk(12'h0A8, 32'h0000_0007);
        wr(12'h014, 32'h0000_1000);
        wr(12'h00C, 32'h0000_0009);
        pulse();
        wpoll(12'h004, 32'h0000_0008);
        rchk(12'h0A8, 32'h0000_0007);
        rchk(12'h0AC, 32'h0000_0188);
        wr(12'h100, 32'h0000_0001);
        wr(12'h030, 32'h0000_0002);
        wr(12'h00C, 32'h0000_0008);
        pulse();
        wpoll(12'h004, 32'h0000_0008);
        rchk(12'h0A8, 32'h0000_0009);
        wr(12'h014, 32'h0000_100F);
        wr(12'h00C, 32'h0000_0009);
        pulse();
        wpoll(12'h004, 32'h0000_0009);
    endtask
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        aresetn = 1'b0;
        slow = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        periph_trig = 4'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_seq0();
        t_seq3();
        t_mix();
        results();
    end
endmodule
